//--- include/csc_regs.vh
// constants for the configuration sequence controller
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
// sequencer state codes
`define CSC_ST_W 3
`define CSC_ST_IDLE 3'h0
`define CSC_ST_CLEAR 3'h1
`define CSC_ST_HOLD 3'h2
`define CSC_ST_LOAD 3'h3
`define CSC_ST_RESET 3'h4
`define CSC_ST_DONE 3'h5
`define CSC_ST_GTS 3'h6
`define CSC_ST_RUN 3'h7
// default counts in config-clock cycles
`define CSC_CLEAR_CYCLES 16
`define CSC_RESET_CYCLES 1
`define CSC_CNT_W 16
`endif

//--- src/csc_sequencer.v
// configuration sequencer: clear, load, start-up
`timescale 1ns/1ps
`include "csc_regs.vh"

module csc_sequencer #(
    parameter CLEAR_CYCLES = `CSC_CLEAR_CYCLES,
    parameter RESET_CYCLES = `CSC_RESET_CYCLES
) (
    input wire ref_clk,
    input wire rstn,
    input wire clk_en,
    input wire program_request_n,
    input wire init_n_in,
    input wire last_frame,
    output reg init_n_out,
    output reg init_n_oe_n,
    output reg load_active,
    output reg done,
    output reg global_flop_reset,
    output reg global_output_tristate,
    output reg global_store_enable
);

    reg [`CSC_ST_W-1:0] state_q;
    reg [`CSC_ST_W-1:0] state_d;
    reg [`CSC_CNT_W-1:0] cnt_q;
    reg [`CSC_CNT_W-1:0] cnt_d;

    localparam [`CSC_CNT_W-1:0] CLEAR_LAST = CLEAR_CYCLES - 1;
    localparam [`CSC_CNT_W-1:0] RESET_LAST = RESET_CYCLES - 1;

    // phase walk in brief:
    //   idle  - one cycle after reset, then straight into clearing
    //   clear - the init line is pulled low for CLEAR_CYCLES enabled edges
    //   hold  - init line released; we wait here while anyone keeps it low
    //   load  - frames are accepted until the far side marks the last one
    //   reset - the global flop reset pulses for RESET_CYCLES edges
    //   done  - done rises, outputs still tristated
    //   gts   - one cycle later the output tristate lets go
    //   run   - one cycle later user storage may write
    // hazards and limits:
    //   the counter is shared by clear and reset; it is zeroed on entry to
    //   either phase so a leftover count never shortens the next phase
    //   the counter runs on freely in the other phases; it may wrap there,
    //   which is harmless since nothing reads it outside clear and reset
    //   program request is a level, not an edge: held low it parks the
    //   sequencer in clear, which keeps the init line low the whole time
    //   every output is a flop, all but the constant init_n_out fed from the next state, so outputs change
    //   on the same edge as the state and never glitch between phases
    //   clk_en low freezes state, counter and outputs alike; a program
    //   request seen only while frozen is ignored
    //   last_frame outside load and init_n_in outside hold are ignored, so
    //   a stray pulse from the far side cannot skip a phase
    //   CLEAR_CYCLES and RESET_CYCLES must be at least one

    // next-state logic; a program request wins over every phase
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q + 16'h0001;
        if (!program_request_n) begin
            state_d = `CSC_ST_CLEAR;
            cnt_d = 16'h0000;
        end else begin
            case (state_q)
                `CSC_ST_IDLE: begin
                    state_d = `CSC_ST_CLEAR;
                    cnt_d = 16'h0000;
                end
                `CSC_ST_CLEAR: begin
                    if (cnt_q >= CLEAR_LAST) begin
                        state_d = `CSC_ST_HOLD;
                    end
                end
                `CSC_ST_HOLD: begin
                    // init line is sampled while released; outside pull-low holds us here
                    if (init_n_in) begin
                        state_d = `CSC_ST_LOAD;
                    end
                end
                `CSC_ST_LOAD: begin
                    if (last_frame) begin
                        state_d = `CSC_ST_RESET;
                        cnt_d = 16'h0000;
                    end
                end
                `CSC_ST_RESET: begin
                    if (cnt_q >= RESET_LAST) begin
                        state_d = `CSC_ST_DONE;
                    end
                end
                `CSC_ST_DONE: begin
                    state_d = `CSC_ST_GTS;
                end
                `CSC_ST_GTS: begin
                    state_d = `CSC_ST_RUN;
                end
                `CSC_ST_RUN: begin
                    state_d = `CSC_ST_RUN;
                end
                default: begin
                    state_d = `CSC_ST_IDLE;
                end
            endcase
        end
    end

    // next-state phase decode shared by the output flops
    wire nxt_clear = (state_d == `CSC_ST_CLEAR);
    wire nxt_load = (state_d == `CSC_ST_LOAD);
    wire nxt_reset = (state_d == `CSC_ST_RESET);
    wire nxt_done = (state_d == `CSC_ST_DONE);
    wire nxt_gts = (state_d == `CSC_ST_GTS);
    wire nxt_run = (state_d == `CSC_ST_RUN);

    // state and phase counter; clk_en low freezes everything
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= `CSC_ST_IDLE;
            cnt_q <= 16'h0000;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // open-drain data value; only the enable ever moves
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            init_n_out <= 1'b0;
        end else if (clk_en) begin
            init_n_out <= 1'b0;
        end
    end

    // drive low while clearing, release afterwards so the line rises
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            init_n_oe_n <= 1'b0;
        end else if (clk_en) begin
            init_n_oe_n <= nxt_clear ? 1'b0 : 1'b1;
        end
    end

    // data accepted only in the load phase
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            load_active <= 1'b0;
        end else if (clk_en) begin
            load_active <= nxt_load;
        end
    end

    // held through clearing too, so user flops stay in reset until hold
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            global_flop_reset <= 1'b1;
        end else if (clk_en) begin
            global_flop_reset <= nxt_reset || nxt_clear;
        end
    end

    // done stays up through the start-up steps and afterwards
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else if (clk_en) begin
            done <= nxt_done || nxt_gts || nxt_run;
        end
    end

    // outputs turn on one cycle after done
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            global_output_tristate <= 1'b1;
        end else if (clk_en) begin
            global_output_tristate <= !(nxt_gts || nxt_run);
        end
    end

    // storage writes allowed one cycle after the outputs turn on
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            global_store_enable <= 1'b0;
        end else if (clk_en) begin
            global_store_enable <= nxt_run;
        end
    end

endmodule

//--- dv/csc_checker.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
module csc_checker(input wire ref_clk, input wire rstn, input wire clk_en, input wire program_request_n,
    input wire init_n_in, input wire last_frame, input wire init_n_out, input wire init_n_oe_n,
    input wire load_active, input wire done, input wire global_flop_reset,
    input wire global_output_tristate, input wire global_store_enable);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_gts_after_done: assert property ($rose(done) && clk_en |=> $fell(global_output_tristate))
        else $error("late gts");
    a_gse_after_gts: assert property ($fell(global_output_tristate) && clk_en |=> $rose(global_store_enable))
        else $error("late gse");
    a_reset_before_done: assert property ($rose(done) |-> $past(global_flop_reset))
        else $error("no gfr");
    a_load_needs_init: assert property ($rose(load_active) |-> $past(init_n_in))
        else $error("early load");
    a_prog_restarts: assert property (!program_request_n && clk_en |=> !init_n_oe_n && !load_active && !done)
        else $error("no restart");
    a_clear_pulls_low: assert property (!init_n_oe_n |-> !init_n_out && !load_active && global_flop_reset)
        else $error("bad clear");
    a_store_held: assert property (global_store_enable |-> done && !global_output_tristate)
        else $error("early gse");
    a_done_last: assert property (done |-> !load_active && init_n_oe_n)
        else $error("bad done");
endmodule
bind csc_sequencer csc_checker chk(.*);

//--- dv/csc_partner.sv
// far side: delays the load, then marks the last frame
`timescale 1ns/1ps
module csc_partner(
    input wire ref_clk,
    input wire hold,
    input wire load_active,
    output wire pull_n,
    output reg last_frame = 1'b0
);
    reg [3:0] n_q = 4'h0;
    assign pull_n = ~hold; // only pulls low or lets go
    // a short load keeps the run brief
    always @(posedge ref_clk) begin
        n_q <= load_active ? n_q + 4'h1 : 4'h0;
        last_frame <= (n_q == 4'h2);
    end
endmodule

//--- dv/csc_sequencer_bench.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
module csc_sequencer_bench;
    reg ref_clk = 0, rstn = 0, clk_en = 1, program_request_n = 1, hold = 1;
    wire init_n_oe_n, init_n_out, load_active, done, global_flop_reset, global_output_tristate;
    wire global_store_enable, pull_n, last_frame;
    wire init_n_in = (init_n_oe_n | init_n_out) & pull_n; // low wins on the wire
    integer n_fail = 0, n_checks = 0, i, k;
    csc_sequencer #(.CLEAR_CYCLES(4)) dut(.*);
    csc_partner peer(.*);
    initial forever #5 ref_clk = ~ref_clk;
    task results; begin
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end endtask
    task check(input string what, input [2:0] seen, input [2:0] exp); begin
        n_checks = n_checks + 1;
        if (seen !== exp) begin n_fail = n_fail + 1; $display("wrong value %s exp %h seen %h", what, exp, seen); end
    end endtask
    // bounded wait, 0 for load, 1 for done
    task w(input integer s); begin
        k = 0;
        while ((s ? done : load_active) !== 1'b1 && k < 60) begin @(posedge ref_clk); #1; k = k + 1; end
        if (k == 60) begin n_fail = n_fail + 1; results; end
    end endtask
    initial begin
        k = $urandom(39);
        repeat (4) @(posedge ref_clk);
        rstn <= 1;
        for (i = 0; i < 4; i = i + 1) begin
            repeat (8 + $urandom % 6) @(posedge ref_clk);
            #1 check("hold", {load_active, init_n_oe_n, global_output_tristate}, 3'h3);
            @(posedge ref_clk) hold <= 0;
            w(0);
            if (i == 1) begin
                @(posedge ref_clk) program_request_n <= 0;
                @(posedge ref_clk) program_request_n <= 1;
                #1 check("abort", {load_active, init_n_oe_n, global_flop_reset}, 3'h1);
                w(0);
            end
            check("load", {global_flop_reset, init_n_in, done}, 3'h2);
            w(1);
            check("done", {done, global_output_tristate, global_store_enable}, 3'h6);
            @(posedge ref_clk) #1 check("gts", {done, global_output_tristate, global_store_enable}, 3'h4);
            @(posedge ref_clk) #1 check("gse", {done, global_output_tristate, global_store_enable}, 3'h5);
            @(posedge ref_clk) begin clk_en <= 0; program_request_n <= 0; end
            repeat (1 + $urandom % 3) @(posedge ref_clk);
            #1 check("frozen", {done, init_n_oe_n, load_active}, 3'h6);
            @(posedge ref_clk) clk_en <= 1;
            @(posedge ref_clk) program_request_n <= 0;
            hold <= 1;
            @(posedge ref_clk) program_request_n <= 1;
            #1 check("prog", {load_active, init_n_oe_n, done}, 3'h0);
        end
        results;
    end
endmodule
